// File: hdl/bpp_pkg.sv
// Purpose: Shared constants and carriers for the bidirectional port block
// Assumes: APB with 32-bit data, one aligned word per register
// Notes: Port count is a module parameter of the top; pins per port is a package constant fixed at eight
package bpp_pkg;
    localparam int unsigned PINS_PER_PORT = 8;
    localparam int unsigned ADDR_W = 12;
    // Register map: three words per port, then one global control word
    localparam logic [11:0] OFF_INPUT_SAMPLE = 12'h000;
    localparam logic [11:0] OFF_DIRECTION = 12'h004;
    localparam logic [11:0] OFF_OUTPUT_DATA = 12'h008;
    localparam logic [11:0] PORT_STRIDE = 12'h010;
    localparam logic [11:0] OFF_MCU_CONTROL = 12'h100;
    localparam int unsigned PUD_BIT = 4;
    localparam logic [7:0] RST_OUTPUT_DATA = 8'h00;
    localparam logic [7:0] RST_DIRECTION = 8'h00;
    localparam logic RST_PUD = 1'b0;
    localparam int unsigned LINK_PERIOD_NS = 8;

    typedef struct packed {
        logic [7:0] drive_val;
        logic [7:0] drive_oe_n;
        logic [7:0] pullup_en;
    } bpp_pad_s;
endpackage : bpp_pkg

// File: hdl/bpp_port.sv
// Purpose: Bank of general-purpose bidirectional port pins behind APB
// Assumes: pin_in is the pad level; pin_out/pin_oe_n/pin_pullup go to pads
// Notes: Input sampled by a high-transparent latch then a rising-edge flop
//
// Decided for this implementation: the APB slave port and the register offsets.
`timescale 1ns/10ps
module bpp_port #(
    parameter int unsigned NUM_PORTS = 1
) (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [bpp_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [NUM_PORTS*8-1:0] pin_in,
    output logic [NUM_PORTS*8-1:0] pin_out,
    output logic [NUM_PORTS*8-1:0] pin_oe_n,
    output logic [NUM_PORTS*8-1:0] pin_pullup,
    input wire logic [NUM_PORTS*8-1:0] alt_fn_en,
    input wire logic [NUM_PORTS*8-1:0] alt_oe,
    input wire logic [NUM_PORTS*8-1:0] alt_out
);
    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    if (NUM_PORTS < 1 || NUM_PORTS > 15) begin : g_chk
        $error("NUM_PORTS must lie in 1..15");
    end
    if (bpp_pkg::PINS_PER_PORT != 8) begin : g_chk_w
        $error("Port width fixed at eight pins");
    end

    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    logic rst_s1_r;
    logic rst_s2_r;
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_s1_r <= 1'b0;
            rst_s2_r <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_s2_r <= rst_s1_r;
        end
    end
    wire logic rst_n = rst_s2_r;

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    wire logic acc = psel && penable;
    wire logic wr_acc = acc && pwrite && pstrb[0];
    wire logic [3:0] port_idx = paddr[7:4];
    wire logic [11:0] port_off = {8'h00, paddr[3:0]};
    wire logic in_port_area = (paddr[11:8] == 4'h0) && (32'(port_idx) < NUM_PORTS)
        && (port_off == bpp_pkg::OFF_INPUT_SAMPLE || port_off == bpp_pkg::OFF_DIRECTION
        || port_off == bpp_pkg::OFF_OUTPUT_DATA);
    wire logic hit_ctl = (paddr == bpp_pkg::OFF_MCU_CONTROL);
    wire logic mapped = in_port_area || hit_ctl;

    // ------------------------------------------------------------
    // Global control
    // ------------------------------------------------------------
    logic pud_r;
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pud_r <= bpp_pkg::RST_PUD;
        end else if (clk_en && wr_acc && hit_ctl) begin
            pud_r <= pwdata[bpp_pkg::PUD_BIT];
        end
    end

    // ------------------------------------------------------------
    // Per-port storage and pin logic
    // ------------------------------------------------------------
    logic [7:0] out_r [NUM_PORTS];
    logic [7:0] dir_r [NUM_PORTS];
    logic [7:0] sample_r [NUM_PORTS];
    logic [7:0] sync_latch [NUM_PORTS];
    logic [7:0] rd_word [NUM_PORTS];

    for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
        wire logic sel = (32'(port_idx) == p) && (paddr[11:8] == 4'h0);
        wire logic wr_out = wr_acc && sel && port_off == bpp_pkg::OFF_OUTPUT_DATA;
        wire logic wr_dir = wr_acc && sel && port_off == bpp_pkg::OFF_DIRECTION;
        wire logic wr_tgl = wr_acc && sel && port_off == bpp_pkg::OFF_INPUT_SAMPLE;
        // Toggle touches only bits written one
        wire logic [7:0] out_nxt = wr_out ? pwdata[7:0] : (wr_tgl ? out_r[p] ^ pwdata[7:0] : out_r[p]);
        always_ff @(posedge ref_clk or negedge rst_n) begin
            if (!rst_n) begin
                out_r[p] <= bpp_pkg::RST_OUTPUT_DATA;
                dir_r[p] <= bpp_pkg::RST_DIRECTION;
            end else if (clk_en) begin
                out_r[p] <= out_nxt;
                if (wr_dir) begin
                    dir_r[p] <= pwdata[7:0];
                end
            end
        end

        // Alternate pins override only themselves; the rest stay plain I/O
        wire logic [7:0] alt = alt_fn_en[p*8 +: 8];
        wire logic [7:0] eff_oe = (alt & alt_oe[p*8 +: 8]) | (~alt & dir_r[p]);
        wire logic [7:0] eff_val = (alt & alt_out[p*8 +: 8]) | (~alt & out_r[p]);
        // Drivers and pull-ups gate on raw reset so pins float with no clock
        assign pin_oe_n[p*8 +: 8] = arst_n && rst_n ? ~eff_oe : 8'hFF;
        assign pin_out[p*8 +: 8] = eff_val;
        assign pin_pullup[p*8 +: 8] = (arst_n && rst_n && !pud_r) ? (~eff_oe & ~alt & out_r[p]) : 8'h00;

        // Latch open while clock high, closes on falling edge
        // Non-blocking so the flop below still sees the held value at the opening edge
        always_latch begin
            if (ref_clk) begin
                sync_latch[p] <= pin_in[p*8 +: 8];
            end
        end
        // Driven pins reach the sample one period after the write edge
        always_ff @(posedge ref_clk or negedge rst_n) begin
            if (!rst_n) begin
                sample_r[p] <= 8'h00;
            end else if (clk_en) begin
                sample_r[p] <= sync_latch[p];
            end
        end

        assign rd_word[p] = (port_off == bpp_pkg::OFF_INPUT_SAMPLE) ? sample_r[p]
            : (port_off == bpp_pkg::OFF_DIRECTION) ? dir_r[p] : out_r[p];
    end

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    logic [7:0] rd_sel;
    always_comb begin
        rd_sel = 8'h00;
        for (int i = 0; i < NUM_PORTS; i++) begin
            if (32'(port_idx) == i) begin
                rd_sel = rd_word[i];
            end
        end
    end
    wire logic [31:0] rd_nxt = hit_ctl ? (32'h0000_0001 << bpp_pkg::PUD_BIT) & {31'h0, pud_r} << bpp_pkg::PUD_BIT
        : (in_port_area ? {24'h000000, rd_sel} : 32'h0000_0000);

    assign prdata = rd_nxt;
    assign pready = 1'b1;
    assign pslverr = acc && !mapped;
endmodule : bpp_port

// File: sim/bpp_port_sva.sv
// Purpose: port checks for bpp_port. Assumes: one port; write checks fire only with clk_en high and pstrb[0] set. Notes: sees ports only
`timescale 1ns/10ps
module bpp_port_sva #(parameter int unsigned NUM_PORTS = 1) (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic clk_en,
    input wire logic [3:0] pstrb,
    input wire logic [NUM_PORTS*8-1:0] alt_fn_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [bpp_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    input wire logic [NUM_PORTS*8-1:0] pin_out,
    input wire logic [NUM_PORTS*8-1:0] pin_oe_n,
    input wire logic [NUM_PORTS*8-1:0] pin_pullup);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    // Only writes the design takes: enabled clock, low byte strobed, plain GPIO on port 0
    wire wr = psel && penable && pwrite && clk_en && pstrb[0] && (alt_fn_en[7:0] == 8'h00);
    wire [7:0] drv = pin_out[7:0], oen = pin_oe_n[7:0];
    a_reset_float: assert property (disable iff (1'b0) !arst_n |-> &pin_oe_n && pin_pullup == '0) else $error("not tri");
    a_pull_input: assert property ((pin_pullup & ~pin_oe_n) == '0) else $error("pull on output");
    a_dir_write: assert property (wr && paddr == 12'h004 |=> oen == ~$past(pwdata[7:0])) else $error("dir");
    a_data_drive: assert property (wr && paddr == 12'h008 |=>
        (drv | oen) == ($past(pwdata[7:0]) | oen)) else $error("drive");
    a_pin_toggle: assert property (wr && paddr == 12'h000 |=>
        ((drv ^ $past(drv)) | oen) == ($past(pwdata[7:0]) | oen)) else $error("toggle");
    a_unmapped_err: assert property (psel && penable && !(paddr inside {12'h000, 12'h004, 12'h008, 12'h100}) |->
        pslverr && prdata == '0) else $error("unmapped");
    a_pud_off: assert property (wr && paddr == 12'h100 && pwdata[4] |=> pin_pullup == '0) else $error("pud");
    a_read_upper: assert property (psel && penable && !pwrite |-> prdata[31:8] == '0) else $error("upper");
    c_toggle: cover property (wr && paddr == 12'h000);
    c_unmapped: cover property (psel && penable && pslverr);
    c_pullup: cover property (|pin_pullup);
    c_frozen: cover property (psel && penable && pwrite && !clk_en);
endmodule : bpp_port_sva
bind bpp_port bpp_port_sva #(.NUM_PORTS(NUM_PORTS)) chk_i (.*);

// File: sim/bpp_pads.sv
// Purpose: board model for one port. Assumes: ext_en pins are board-driven. Notes: no contention modelled
`timescale 1ns/10ps
module bpp_pads (
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe_n,
    input wire logic [7:0] pin_pullup,
    input wire logic [7:0] ext_en,
    input wire logic [7:0] ext_val,
    output logic [7:0] pin_in);
    // Floating pins read the inverse of the drive value so a missing pull-up cannot pass by luck
    assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & ((ext_en & ext_val) | (~ext_en & (pin_pullup | ~pin_out))));
endmodule : bpp_pads

// File: sim/bpp_port_tb.sv
// Purpose: directed APB test of bpp_port. Assumes: one port, alternate functions off. Notes: pins 4-5 board-driven
`timescale 1ns/10ps
module bpp_port_tb;
    logic ref_clk = 1'b0, arst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata;
    logic [7:0] pin_in, pin_out, pin_oe_n, pin_pullup;
    logic clk_en = 1'b1;
    logic [3:0] pstrb = 4'hF;
    logic [7:0] ext_val = 8'h10;
    int err_count = 0, tests_run = 0;
    initial forever #4 ref_clk = ~ref_clk;
    bpp_port #(.NUM_PORTS(1)) uut (.ref_clk(ref_clk), .arst_n(arst_n), .clk_en(clk_en), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
        .pin_pullup(pin_pullup), .alt_fn_en(8'h00), .alt_oe(8'h00), .alt_out(8'h00));
    bpp_pads pads (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_pullup(pin_pullup), .ext_en(8'h30),
        .ext_val(ext_val), .pin_in(pin_in));
    initial begin
        repeat (1000) @(posedge ref_clk);
        close_out(1);
    end
    task close_out(input int miss);
        err_count += miss;
        if (err_count == 0 && tests_run > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : close_out
    task chk(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e) $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
        err_count += (g !== e);
    endtask : chk
    task xfer(input logic w, input logic [11:0] a, input logic [31:0] d, input logic e);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, w ? d : 32'h0};
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        if (!w) chk(prdata, d);
        chk({31'h0, pslverr}, {31'h0, e});
        {psel, penable} <= 2'b00;
        @(posedge ref_clk);
    endtask : xfer
    initial begin
        repeat (4) @(posedge ref_clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge ref_clk);
        xfer(1'b1, 12'h008, 32'hC3, 1'b0);
        xfer(1'b1, 12'h004, 32'h0F, 1'b0);
        chk({8'h00, pin_oe_n, pin_pullup, pin_out & ~pin_oe_n}, 32'h00F0C003);
        xfer(1'b0, 12'h000, 32'hD3, 1'b0);
        xfer(1'b1, 12'h000, 32'h45, 1'b0);
        xfer(1'b0, 12'h008, 32'h86, 1'b0);
        chk({24'h000000, pin_pullup}, 32'h80);
        xfer(1'b1, 12'h100, 32'h10, 1'b0);
        chk({24'h000000, pin_pullup}, 32'h00);
        xfer(1'b0, 12'h100, 32'h10, 1'b0);
        // Writes with the clock enable low or the low strobe clear must not land
        clk_en <= 1'b0;
        xfer(1'b1, 12'h008, 32'h00, 1'b0);
        clk_en <= 1'b1;
        pstrb <= 4'hE;
        xfer(1'b1, 12'h004, 32'hFF, 1'b0);
        pstrb <= 4'hF;
        xfer(1'b0, 12'h008, 32'h86, 1'b0);
        xfer(1'b0, 12'h004, 32'h0F, 1'b0);
        // Pin 7 from input with pull-ups disabled to output low by way of output high
        xfer(1'b1, 12'h004, 32'h8F, 1'b0);
        xfer(1'b1, 12'h008, 32'h06, 1'b0);
        chk({16'h0000, pin_oe_n, pin_out & ~pin_oe_n}, 32'h7006);
        xfer(1'b0, 12'h000, 32'h56, 1'b0);
        ext_val <= 8'h20;
        xfer(1'b0, 12'h000, 32'h66, 1'b0);
        xfer(1'b0, 12'h00C, 32'h00, 1'b1);
        // Reset in mid-run floats every pin and clears the registers
        arst_n <= 1'b0;
        @(posedge ref_clk);
        chk({16'h0000, pin_oe_n, pin_pullup}, 32'hFF00);
        arst_n <= 1'b1;
        repeat (3) @(posedge ref_clk);
        xfer(1'b0, 12'h004, 32'h00, 1'b0);
        xfer(1'b0, 12'h100, 32'h00, 1'b0);
        close_out(0);
    end
endmodule : bpp_port_tb
